// [verilog/paged_address_translator.sv]
// paged logical-to-physical translation with access protection
`timescale 1ns/100ps
module paged_address_translator (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  wire xlate_pkg::cpu_req_t           cpu,
  input  wire xlate_pkg::io_req_t            io,
  output logic      [xlate_pkg::ENT_W-1:0]   io_rdata,
  output logic                               io_ack,
  output logic      [xlate_pkg::PHYS_W-1:0]  phys_addr,
  output logic                               mem_req,
  output logic                               trap_req,
  output logic                               xlate_on
);

  typedef struct packed {
    logic                         en;
    logic                         sep;
    logic [xlate_pkg::PHYS_W-1:0] phys;
    logic                         mreq;
    logic                         trap;
    logic [xlate_pkg::ENT_W-1:0]  rdata;
    logic                         ack;
  } xl_st_t;

  xl_st_t st_r;
  xl_st_t st_nxt;

  logic [xlate_pkg::IDX_W-1:0]  lk_idx;
  logic [xlate_pkg::ENT_W-1:0]  lk_data;
  logic [xlate_pkg::ENT_W-1:0]  io_data;
  logic                         io_is_ent;
  logic                         io_is_ctrl;
  logic                         violation;
  logic                         mod_set;
  logic [xlate_pkg::PHYS_W-1:0] phys_calc;

  // I/O bit above the bank bits is clear for entries
  assign io_is_ent  = ~io.addr[xlate_pkg::IOA_W-1];
  assign io_is_ctrl = (io.addr == xlate_pkg::IO_CTRL);

  // system bank at index 0-15, user at 16-31
  assign lk_idx = xlate_pkg::entry_index(cpu.sys_mode, st_r.sep,
                                         cpu.prog_data, cpu.log_addr);

  // invalid entry, or write through a locked one
  assign violation = st_r.en && cpu.valid &&
                     (!lk_data[xlate_pkg::A_VALID] ||
                      (cpu.write && lk_data[xlate_pkg::A_LOCK]));

  // only clean writes mark the page dirty
  assign mod_set = st_r.en && cpu.valid && cpu.write && !violation;

  always_comb begin
    if (!st_r.en) begin
      phys_calc = {xlate_pkg::HI_ZERO, cpu.log_addr};
    end else if (st_r.sep) begin
      // 8K page
      phys_calc = {lk_data[xlate_pkg::FRM8K_W-1:0],
                   cpu.log_addr[xlate_pkg::OFF8K_W-1:0]};
    end else begin
      // 4K page
      phys_calc = {lk_data[xlate_pkg::FRM4K_W-1:0],
                   cpu.log_addr[xlate_pkg::OFF4K_W-1:0]};
    end
  end

  descriptor_bank u_bank (
    .mclk    (mclk),
    .resetn  (resetn),
    .ce      (ce),
    .wr_en   (io.req && io.wr && io_is_ent),
    .wr_idx  (io.addr[xlate_pkg::IDX_W-1:0]),
    .wr_data (io.wdata),
    .mod_set (mod_set),
    .mod_idx (lk_idx),
    .lk_idx  (lk_idx),
    .lk_data (lk_data),
    .io_idx  (io.addr[xlate_pkg::IDX_W-1:0]),
    .io_data (io_data)
  );

  always_comb begin
    st_nxt      = st_r;
    st_nxt.mreq = 1'b0;
    st_nxt.trap = 1'b0;
    st_nxt.ack  = 1'b0;
    if (cpu.valid) begin
      st_nxt.phys = phys_calc;
      st_nxt.mreq = !violation;
      st_nxt.trap = violation;
    end
    if (io.req) begin
      st_nxt.ack = 1'b1;
      if (io.wr && io_is_ctrl) begin
        st_nxt.en  = io.wdata[xlate_pkg::CTRL_EN];
        st_nxt.sep = io.wdata[xlate_pkg::CTRL_SEP];
      end
      if (!io.wr) begin
        // unmapped I/O addresses read as zero
        if (io_is_ent) begin
          st_nxt.rdata = io_data;
        end else if (io_is_ctrl) begin
          st_nxt.rdata = xlate_pkg::CTRL_RESET;
          st_nxt.rdata[xlate_pkg::CTRL_EN]  = st_r.en;
          st_nxt.rdata[xlate_pkg::CTRL_SEP] = st_r.sep;
        end else begin
          st_nxt.rdata = xlate_pkg::CTRL_RESET;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign phys_addr = st_r.phys;
  assign mem_req   = st_r.mreq;
  assign trap_req  = st_r.trap;
  assign io_rdata  = st_r.rdata;
  assign io_ack    = st_r.ack;
  assign xlate_on  = st_r.en;

  // protocol and translation checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_access;
    ce && cpu.valid;
  endsequence

  sequence s_bad_access;
    ce && cpu.valid && violation;
  endsequence

  // ce low holds the pulse for another cycle
  sequence s_one_pulse_trap;
    trap_req && !mem_req ##1 (!trap_req || $past(!ce || cpu.valid));
  endsequence

  passthru_addr_a: assert property (
    s_access and (!st_r.en) |=>
      phys_addr == {xlate_pkg::HI_ZERO, $past(cpu.log_addr)} && mem_req)
    else $error("disabled access not passed through");

  off_after_reset_a: assert property (
    $rose(resetn) |-> !xlate_on)
    else $error("translation on after reset");

  invalid_trap_a: assert property (
    s_access and (st_r.en && !lk_data[xlate_pkg::A_VALID]) |=>
      s_one_pulse_trap)
    else $error("invalid entry did not trap");

  lock_trap_a: assert property (
    s_access and (st_r.en && cpu.write && lk_data[xlate_pkg::A_LOCK]) |=>
      trap_req && !mem_req)
    else $error("locked write did not trap");

  trap_cause_a: assert property (
    ce ##1 trap_req |-> $past(violation))
    else $error("trap without violation");

  no_mod_on_bad_a: assert property (
    s_bad_access |-> !mod_set ##1 !mem_req)
    else $error("violating access went through");

  small_page_a: assert property (
    s_access and (st_r.en && !st_r.sep && !violation) |=>
      phys_addr == {$past(lk_data[xlate_pkg::FRM4K_W-1:0]),
                    $past(cpu.log_addr[xlate_pkg::OFF4K_W-1:0])})
    else $error("4K translation wrong");

  big_page_a: assert property (
    s_access and (st_r.en && st_r.sep && !violation) |=>
      phys_addr == {$past(lk_data[xlate_pkg::FRM8K_W-1:0]),
                    $past(cpu.log_addr[xlate_pkg::OFF8K_W-1:0])})
    else $error("8K translation wrong");

  sep_index_a: assert property (
    st_r.en && st_r.sep |->
      lk_idx[xlate_pkg::IDX_W-2:0] ==
        {cpu.prog_data, cpu.log_addr[xlate_pkg::LOG_W-1:xlate_pkg::OFF8K_W]})
    else $error("separated index wrong");

  bank_select_a: assert property (
    lk_idx[xlate_pkg::IDX_W-1] == !cpu.sys_mode)
    else $error("wrong bank for mode");

  io_answer_a: assert property (
    ce && io.req |=> io_ack ##1 (!io_ack || $past(!ce || io.req)))
    else $error("I/O access not answered");

  one_answer_a: assert property (
    s_access |=> mem_req != trap_req)
    else $error("access not answered exactly once");

  quiet_idle_a: assert property (
    ce && !cpu.valid |=> !mem_req && !trap_req)
    else $error("answer without an access");

  ctrl_write_a: assert property (
    ce && io.req && io.wr && io_is_ctrl |=>
      xlate_on == $past(io.wdata[xlate_pkg::CTRL_EN]) &&
      st_r.sep == $past(io.wdata[xlate_pkg::CTRL_SEP]))
    else $error("control write not applied");

  never_trap_off_a: assert property (
    ce && !st_r.en |=> !trap_req)
    else $error("trap while translation disabled");

  read_back_a: assert property (
    ce && io.req && !io.wr && io_is_ent |=> io_rdata == $past(io_data))
    else $error("entry read data wrong");

  locked_read_ok_a: assert property (
    s_access and (st_r.en && !cpu.write && lk_data[xlate_pkg::A_VALID]) |=>
      mem_req && !trap_req)
    else $error("valid read was refused");

endmodule : paged_address_translator

// [verilog/xlate_pkg.sv]
// constants, carriers and index decode for the paged address translator
package xlate_pkg;

  localparam int LOG_W   = 16;
  localparam int PHYS_W  = 19;
  localparam int ENT_W   = 16;
  localparam int IDX_W   = 5;
  localparam int N_ENT   = 32;
  localparam int IOA_W   = 6;
  localparam int HI_W    = PHYS_W - LOG_W;
  localparam logic [HI_W-1:0] HI_ZERO = 3'h0;

  // unseparated split: 4-bit index, 12-bit offset, 7 frame bits
  localparam int OFF4K_W = 12;
  localparam int FRM4K_W = 7;
  // separated split: 3-bit index, 13-bit offset, 6 frame bits
  localparam int OFF8K_W = 13;
  localparam int FRM8K_W = 6;

  // entry layout: attribute nibble above 12-bit frame
  localparam int FRAME_W  = 12;
  localparam int A_VALID  = 15;
  localparam int A_MOD    = 14;
  localparam int A_LOCK   = 13;
  localparam int A_RSVD   = 12;
  localparam logic [ENT_W-1:0] ENT_RESET = 16'h0000;

  // I/O map: 0x00-0x0f system bank, 0x10-0x1f user bank, 0x20 control
  localparam logic [IOA_W-1:0] IO_CTRL   = 6'h20;
  localparam int               IO_BANKB  = 4;
  localparam int               CTRL_EN   = 0;
  localparam int               CTRL_SEP  = 1;
  localparam logic [ENT_W-1:0] CTRL_RESET = 16'h0000;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic             sys_mode;
    logic             prog_data;
    logic [LOG_W-1:0] log_addr;
  } cpu_req_t;

  typedef struct packed {
    logic             req;
    logic             wr;
    logic [IOA_W-1:0] addr;
    logic [ENT_W-1:0] wdata;
  } io_req_t;

  // bank select on the top bit, page index below it
  function automatic logic [IDX_W-1:0] entry_index(
    input logic             sys_mode,
    input logic             sep,
    input logic             prog_data,
    input logic [LOG_W-1:0] a);
    logic [IDX_W-2:0] page;
    page = sep ? {prog_data, a[LOG_W-1:OFF8K_W]} : a[LOG_W-1:OFF4K_W];
    return {~sys_mode, page};
  endfunction : entry_index

endpackage : xlate_pkg

// [verilog/descriptor_bank.sv]
// storage for the 32 page map entries, two banks of 16
`timescale 1ns/100ps
module descriptor_bank (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic                         ce,
  input  wire logic                         wr_en,
  input  wire logic [xlate_pkg::IDX_W-1:0]  wr_idx,
  input  wire logic [xlate_pkg::ENT_W-1:0]  wr_data,
  input  wire logic                         mod_set,
  input  wire logic [xlate_pkg::IDX_W-1:0]  mod_idx,
  input  wire logic [xlate_pkg::IDX_W-1:0]  lk_idx,
  output logic      [xlate_pkg::ENT_W-1:0]  lk_data,
  input  wire logic [xlate_pkg::IDX_W-1:0]  io_idx,
  output logic      [xlate_pkg::ENT_W-1:0]  io_data
);

  typedef struct packed {
    logic [xlate_pkg::N_ENT-1:0][xlate_pkg::ENT_W-1:0] ent;
  } bank_st_t;

  bank_st_t st_r;
  bank_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.ent[wr_idx] = wr_data;
    end
    // applied after the I/O write so a set beats a clear
    if (mod_set) begin
      st_nxt.ent[mod_idx][xlate_pkg::A_MOD] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{ent: {xlate_pkg::N_ENT{xlate_pkg::ENT_RESET}}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign lk_data = st_r.ent[lk_idx];
  assign io_data = st_r.ent[io_idx];

  mod_flag_set_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (ce && mod_set) |=> st_r.ent[$past(mod_idx)][xlate_pkg::A_MOD])
    else $error("modified flag not set after write");

  io_write_lands_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (ce && wr_en && !mod_set) |=>
      st_r.ent[$past(wr_idx)] == $past(wr_data))
    else $error("entry write not stored");

endmodule : descriptor_bank

// [verification/cpu_model.sv]
// cpu core stand-in issuing one logical access per call
`timescale 1ns/100ps
module cpu_model (
  input  wire logic           mclk,
  output xlate_pkg::cpu_req_t cpu
);
  initial cpu = '0;

  task automatic issue(input logic w, s, pd, input logic [15:0] a);
    @(negedge mclk);
    cpu = '{valid: 1'b1, write: w, sys_mode: s, prog_data: pd, log_addr: a};
    @(negedge mclk);
    // released lines flip so a stale address never matches by luck
    cpu = '{valid: 1'b0, write: ~w, sys_mode: ~s, prog_data: ~pd,
            log_addr: ~a};
  endtask : issue
endmodule : cpu_model

// [verification/tb.sv]
// self-checking bench for the paged address translator
`timescale 1ns/100ps
module tb;
  logic                mclk = 1'b0;
  logic                resetn;
  logic                ce;
  xlate_pkg::cpu_req_t cpu;
  xlate_pkg::io_req_t  io;
  logic [15:0]         io_rdata;
  logic                io_ack;
  logic [18:0]         phys_addr;
  logic                mem_req;
  logic                trap_req;
  logic                xlate_on;
  logic [15:0]         rd;
  int                  n_fail = 0;
  int                  total_checks = 0;
  int                  cycles = 0;

  paged_address_translator i_dut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .cpu(cpu), .io(io),
    .io_rdata(io_rdata), .io_ack(io_ack), .phys_addr(phys_addr),
    .mem_req(mem_req), .trap_req(trap_req), .xlate_on(xlate_on));
  cpu_model i_cpu (.mclk(mclk), .cpu(cpu));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, far above the roughly 60 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [18:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic io_op(input logic w, input logic [5:0] a,
                       input logic [15:0] d);
    int k;
    @(negedge mclk);
    io = '{req: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge mclk);
    io = '{req: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
    k = 0;
    while (io_ack !== 1'b1 && k < 3) begin
      @(negedge mclk);
      k++;
    end
    check("io_ack", 19'h1, {18'h0, io_ack});
    rd = io_rdata;
  endtask : io_op

  task automatic access(input logic w, s, pd, input logic [15:0] a,
                        input logic ok, input logic [18:0] p);
    int k;
    i_cpu.issue(w, s, pd, a);
    k = 0;
    while (mem_req !== 1'b1 && trap_req !== 1'b1 && k < 3) begin
      @(negedge mclk);
      k++;
    end
    check("mem_req", {18'h0, ok}, {18'h0, mem_req});
    check("trap_req", {18'h0, ~ok}, {18'h0, trap_req});
    if (ok) begin
      check("phys_addr", p, phys_addr);
    end
  endtask : access

  task automatic t_reset();
    check("xlate_on", 19'h0, {18'h0, xlate_on});
    io_op(1'b0, 6'h20, 16'h0000);
    check("ctrl", 19'h0, {3'h0, rd});
    io_op(1'b0, 6'h05, 16'h0000);
    check("entry", 19'h0, {3'h0, rd});
    access(1'b1, 1'b1, 1'b0, 16'hbeef, 1'b1, {3'h0, 16'hbeef});
  endtask : t_reset

  task automatic t_flat();
    io_op(1'b1, 6'h03, 16'h80ab);
    io_op(1'b1, 6'h13, 16'h8055);
    io_op(1'b1, 6'h20, 16'h0001);
    check("xlate_on", 19'h1, {18'h0, xlate_on});
    access(1'b0, 1'b1, 1'b0, 16'h3123, 1'b1, {7'h2b, 12'h123});
    access(1'b0, 1'b0, 1'b0, 16'h3fff, 1'b1, {7'h55, 12'hfff});
  endtask : t_flat

  task automatic t_sep();
    io_op(1'b1, 6'h1d, 16'h80ff);
    io_op(1'b1, 6'h20, 16'h0003);
    access(1'b0, 1'b0, 1'b1, 16'ha456, 1'b1, {6'h3f, 13'h0456});
    access(1'b0, 1'b0, 1'b0, 16'ha456, 1'b0, 19'h0);
    io_op(1'b0, 6'h20, 16'h0000);
    check("ctrl", 19'h3, {3'h0, rd});
  endtask : t_sep

  task automatic t_fault();
    io_op(1'b1, 6'h20, 16'h0001);
    access(1'b0, 1'b1, 1'b0, 16'h7000, 1'b0, 19'h0);
    io_op(1'b1, 6'h04, 16'ha011);
    access(1'b1, 1'b1, 1'b0, 16'h4abc, 1'b0, 19'h0);
    io_op(1'b0, 6'h04, 16'h0000);
    check("locked entry", 19'ha011, {3'h0, rd});
    access(1'b0, 1'b1, 1'b0, 16'h4abc, 1'b1, {7'h11, 12'habc});
    access(1'b1, 1'b1, 1'b0, 16'h3001, 1'b1, {7'h2b, 12'h001});
    io_op(1'b0, 6'h03, 16'h0000);
    check("modified", 19'hc0ab, {3'h0, rd});
    io_op(1'b0, 6'h2a, 16'h0000);
    check("unmapped", 19'h0, {3'h0, rd});
  endtask : t_fault

  // ce low must freeze the control register and the answer
  task automatic t_hold();
    @(negedge mclk);
    ce = 1'b0;
    io = '{req: 1'b1, wr: 1'b1, addr: 6'h20, wdata: 16'h0000};
    repeat (2) @(negedge mclk);
    check("frozen ack", 19'h0, {18'h0, io_ack});
    check("frozen ctrl", 19'h1, {18'h0, xlate_on});
    io = '{req: 1'b0, wr: 1'b0, addr: 6'h1f, wdata: 16'hffff};
    ce = 1'b1;
    io_op(1'b0, 6'h20, 16'h0000);
    check("ctrl kept", 19'h1, {3'h0, rd});
  endtask : t_hold

  // second reset in mid-run clears control and entries
  task automatic t_rerun();
    @(negedge mclk);
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    check("xlate_on", 19'h0, {18'h0, xlate_on});
    io_op(1'b0, 6'h03, 16'h0000);
    check("entry cleared", 19'h0, {3'h0, rd});
    access(1'b0, 1'b0, 1'b1, 16'h1234, 1'b1, {3'h0, 16'h1234});
  endtask : t_rerun

  initial begin
    ce = 1'b1;
    resetn = 1'b0;
    io = '0;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_flat();
    t_sep();
    t_fault();
    t_hold();
    t_rerun();
    tally_and_finish();
  end
endmodule : tb
